// >>> common/ips_pkg.sv
package ips_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam int NUM_SRC = 8;
    localparam int NUM_TRAP = 4;
    localparam int NUM_PRIO = 4;
    localparam int VEC_W = 7;
    localparam int LVL_W = 4;
    localparam int HOLD_W = 14;
    localparam int STACK_DEPTH = 8;

    // ------------------------------------------------------------
    // Register indices
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_PRIO4 = 4'h0;
    localparam logic [ADDR_W-1:0] OFF_PRIO5 = 4'h1;
    localparam logic [ADDR_W-1:0] OFF_PRIO7 = 4'h2;
    localparam logic [ADDR_W-1:0] OFF_PRIO16 = 4'h3;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h4;
    localparam logic [ADDR_W-1:0] OFF_CTRL1 = 4'h5;
    localparam logic [ADDR_W-1:0] OFF_FLAGS = 4'h6;
    localparam logic [ADDR_W-1:0] OFF_ENABLE = 4'h7;
    localparam logic [ADDR_W-1:0] OFF_STAT_LO = 4'h8;
    localparam logic [ADDR_W-1:0] OFF_HOLD = 4'h9;

    // ------------------------------------------------------------
    // Priority registers: implemented bits and reset values
    // ------------------------------------------------------------
    localparam logic [NUM_PRIO-1:0][DATA_W-1:0] PRIO_MASK =
        {16'h0070, 16'h0070, 16'h7707, 16'h7077};
    localparam logic [NUM_PRIO-1:0][DATA_W-1:0] PRIO_RST =
        {16'h0040, 16'h0040, 16'h4404, 16'h4044};
    localparam int PRIO_FLD_W = 3;

    // Source order: pin change, bus master, bus slave, capture8,
    // capture7, ext irq1, ext irq2, serial error
    localparam int SRC_REG [NUM_SRC] = '{0, 0, 0, 1, 1, 1, 2, 3};
    localparam int SRC_POS [NUM_SRC] = '{12, 4, 0, 12, 8, 0, 4, 4};

    // ------------------------------------------------------------
    // Control, status and levels
    // ------------------------------------------------------------
    localparam int NEST_OFF_BIT = 15;
    localparam int TRAP_LSB = 1;
    localparam int STAT_LVL_LSB = 8;
    localparam int STLO_LVL_LSB = 5;
    localparam logic [7:0] STLO_RST = 8'h00;
    localparam logic [7:0] STLO_MASK_ALL = 8'hE0;
    localparam logic [LVL_W-1:0] LVL_USER_MAX = 4'h7;
    localparam logic [LVL_W-1:0] LVL_HOLD_MAX = 4'h6;
    localparam logic [LVL_W-1:0] LVL_TRAP_BASE = 4'hC;
    localparam logic [VEC_W-1:0] VEC_TRAP_BASE = 7'h00;
    localparam logic [VEC_W-1:0] VEC_USER_BASE = 7'h10;
endpackage

// >>> common/ips_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ips_if;
    import ips_pkg::*;
    logic [ADDR_W-1:0] addr;
    logic wr;
    logic rd;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic rvalid;
    logic irq_req;
    logic [LVL_W-1:0] irq_level;
    logic [VEC_W-1:0] irq_vec;
    logic irq_ack;
    logic irq_ret;

    modport dev (
        input addr, wr, rd, wdata, irq_ack, irq_ret,
        output rdata, rvalid, irq_req, irq_level, irq_vec
    );
    modport core (
        output addr, wr, rd, wdata, irq_ack, irq_ret,
        input rdata, rvalid, irq_req, irq_level, irq_vec
    );
endinterface
`default_nettype wire

// >>> src/ips_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module ips_ctrl #(
    parameter int STK = ips_pkg::STACK_DEPTH
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    ips_if.dev bus,
    input wire logic [ips_pkg::NUM_SRC-1:0] src_event_i,
    input wire logic [ips_pkg::NUM_TRAP-1:0] trap_event_i,
    output logic [ips_pkg::LVL_W-1:0] cur_level_o
);
    import ips_pkg::*;

    localparam int DW = $clog2(STK + 1);

    typedef struct packed {
        logic [NUM_PRIO-1:0][DATA_W-1:0] prio;
        logic [NUM_SRC-1:0] flag;
        logic [NUM_SRC-1:0] en;
        logic [NUM_TRAP-1:0] trap;
        logic nest_off;
        logic [7:0] stat_lo;
        logic [LVL_W-1:0] cur;
        logic [HOLD_W-1:0] hold;
        logic [DW-1:0] depth;
        logic [STK-1:0][7+LVL_W:0] stack;
        logic [DATA_W-1:0] status;
        logic [DATA_W-1:0] rdata;
        logic rvalid;
    } ips_dev_st_t;

    ips_dev_st_t s;
    ips_dev_st_t n;

    logic win_v;
    logic [LVL_W-1:0] win_lvl;
    logic [VEC_W-1:0] win_vec;
    logic [DATA_W-1:0] rmux;

    // ------------------------------------------------------------
    // Arbitration
    // ------------------------------------------------------------
    always_comb begin
        logic [LVL_W-1:0] lv;
        logic nest_blk;
        logic hold_on;
        lv = '0;
        nest_blk = s.nest_off && (s.depth != '0);
        hold_on = (s.hold != '0);
        win_v = 1'b0;
        win_lvl = s.cur;
        win_vec = '0;
        for (int i = 0; i < NUM_SRC; i++) begin
            lv = {1'b0, s.prio[SRC_REG[i]][SRC_POS[i] +: PRIO_FLD_W]};
            if (s.flag[i] && s.en[i]
                && (lv != '0)
                && (lv > win_lvl)
                && !(hold_on && (lv <= LVL_HOLD_MAX))
                && !nest_blk) begin
                win_v = 1'b1;
                win_lvl = lv;
                win_vec = VEC_USER_BASE + VEC_W'(i);
            end
        end
        for (int t = 0; t < NUM_TRAP; t++) begin
            lv = LVL_TRAP_BASE + LVL_W'(t);
            if (s.trap[t] && (lv > win_lvl)) begin
                win_v = 1'b1;
                win_lvl = lv;
                win_vec = VEC_TRAP_BASE + VEC_W'(t);
            end
        end
    end

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    always_comb begin
        rmux = '0;
        case (bus.addr)
            OFF_PRIO4: rmux = s.prio[0];
            OFF_PRIO5: rmux = s.prio[1];
            OFF_PRIO7: rmux = s.prio[2];
            OFF_PRIO16: rmux = s.prio[3];
            OFF_STATUS: rmux = s.status;
            OFF_CTRL1: begin
                rmux[NEST_OFF_BIT] = s.nest_off;
                rmux[TRAP_LSB +: NUM_TRAP] = s.trap;
            end
            OFF_FLAGS: rmux[NUM_SRC-1:0] = s.flag;
            OFF_ENABLE: rmux[NUM_SRC-1:0] = s.en;
            OFF_STAT_LO: rmux[7:0] = s.stat_lo;
            OFF_HOLD: rmux[HOLD_W-1:0] = s.hold;
            default: rmux = '0;
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        n = s;
        n.rvalid = 1'b0;
        if (s.hold != '0) begin
            n.hold = s.hold - 1'b1;
        end
        if (bus.wr) begin
            case (bus.addr)
                OFF_PRIO4: n.prio[0] = bus.wdata & PRIO_MASK[0];
                OFF_PRIO5: n.prio[1] = bus.wdata & PRIO_MASK[1];
                OFF_PRIO7: n.prio[2] = bus.wdata & PRIO_MASK[2];
                OFF_PRIO16: n.prio[3] = bus.wdata & PRIO_MASK[3];
                OFF_CTRL1: begin
                    n.nest_off = bus.wdata[NEST_OFF_BIT];
                    n.trap = s.trap & ~bus.wdata[TRAP_LSB +: NUM_TRAP];
                end
                OFF_FLAGS: n.flag = s.flag & ~bus.wdata[NUM_SRC-1:0];
                OFF_ENABLE: n.en = bus.wdata[NUM_SRC-1:0];
                OFF_STAT_LO: begin
                    n.stat_lo = bus.wdata[7:0];
                    if (s.cur <= LVL_USER_MAX) begin
                        n.cur = {1'b0, bus.wdata[STLO_LVL_LSB +: 3]};
                    end
                end
                OFF_HOLD: n.hold = bus.wdata[HOLD_W-1:0];
                default: ;
            endcase
        end
        n.flag = n.flag | src_event_i;
        n.trap = n.trap | trap_event_i;
        if (bus.irq_ret) begin
            if (s.depth != '0) begin
                {n.stat_lo, n.cur} = s.stack[s.depth - 1'b1];
                n.depth = s.depth - 1'b1;
            end
        end else if (bus.irq_ack && win_v) begin
            if (s.depth != DW'(STK)) begin
                n.stack[s.depth] = {s.stat_lo, s.cur};
                n.depth = s.depth + 1'b1;
            end
            n.cur = win_lvl;
            n.stat_lo[STLO_LVL_LSB +: 3] = (win_lvl > LVL_USER_MAX) ?
                LVL_USER_MAX[2:0] : win_lvl[2:0];
        end
        n.status = '0;
        n.status[STAT_LVL_LSB +: LVL_W] = win_v ? win_lvl : s.cur;
        n.status[VEC_W-1:0] = win_vec;
        if (bus.rd) begin
            n.rdata = rmux;
            n.rvalid = 1'b1;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s <= '0;
            s.prio <= PRIO_RST;
            s.stat_lo <= STLO_RST;
        end else if (ce_i) begin
            s <= n;
        end
    end

    assign bus.irq_req = win_v;
    assign bus.irq_level = win_lvl;
    assign bus.irq_vec = win_vec;
    assign bus.rdata = s.rdata;
    assign bus.rvalid = s.rvalid;
    assign cur_level_o = s.cur;
endmodule // ips_ctrl
`default_nettype wire

// >>> src/ips_core.sv
`timescale 1ns/1ps
`default_nettype none
module ips_core (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    ips_if.core bus,
    input wire logic cmd_valid_i,
    input wire logic cmd_write_i,
    input wire logic [ips_pkg::ADDR_W-1:0] cmd_addr_i,
    input wire logic [ips_pkg::DATA_W-1:0] cmd_wdata_i,
    output logic cmd_ready_o,
    output logic rsp_valid_o,
    output logic [ips_pkg::DATA_W-1:0] rsp_data_o,
    input wire logic init_valid_i,
    input wire logic [2:0] init_src_i,
    input wire logic [ips_pkg::ADDR_W-1:0] init_prio_addr_i,
    input wire logic [ips_pkg::DATA_W-1:0] init_prio_word_i,
    input wire logic done_valid_i,
    input wire logic [ips_pkg::VEC_W-1:0] done_vec_i,
    input wire logic take_en_i,
    output logic taken_valid_o,
    output logic [ips_pkg::VEC_W-1:0] taken_vec_o,
    output logic [ips_pkg::LVL_W-1:0] taken_level_o
);
    import ips_pkg::*;

    typedef enum logic [2:0] {
        C_IDLE, C_CMD, C_RD, C_PRIO, C_FLAG, C_EN, C_CLR, C_RET
    } ips_cst_t;

    typedef struct packed {
        ips_cst_t st;
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [2:0] src;
        logic [NUM_SRC-1:0] en_sh;
        logic nst_sh;
        logic [VEC_W-1:0] dvec;
        logic rsp_v;
        logic [DATA_W-1:0] rsp_d;
        logic tk_v;
        logic [VEC_W-1:0] tk_vec;
        logic [LVL_W-1:0] tk_lvl;
    } ips_core_st_t;

    ips_core_st_t s;
    ips_core_st_t n;
    logic ack;

    // ------------------------------------------------------------
    // Bus drive
    // ------------------------------------------------------------
    always_comb begin
        logic [VEC_W-1:0] off;
        off = s.dvec - VEC_USER_BASE;
        bus.addr = s.addr;
        bus.wr = 1'b0;
        bus.rd = 1'b0;
        bus.wdata = '0;
        bus.irq_ret = (s.st == C_RET);
        case (s.st)
            C_CMD: begin
                bus.wr = s.write;
                bus.rd = !s.write;
                bus.wdata = s.data;
            end
            C_PRIO: begin
                bus.wr = 1'b1;
                bus.wdata = s.data;
            end
            C_FLAG: begin
                bus.addr = OFF_FLAGS;
                bus.wr = 1'b1;
                bus.wdata[s.src] = 1'b1;
            end
            C_EN: begin
                bus.addr = OFF_ENABLE;
                bus.wr = 1'b1;
                bus.wdata[NUM_SRC-1:0] = s.en_sh;
            end
            C_CLR: begin
                bus.wr = 1'b1;
                if (s.dvec >= VEC_USER_BASE) begin
                    bus.addr = OFF_FLAGS;
                    bus.wdata[off[2:0]] = 1'b1;
                end else begin
                    bus.addr = OFF_CTRL1;
                    bus.wdata[NEST_OFF_BIT] = s.nst_sh;
                    bus.wdata[TRAP_LSB + 32'(s.dvec[1:0])] = 1'b1;
                end
            end
            default: ;
        endcase
    end

    assign ack = bus.irq_req && take_en_i && (s.st != C_RET);
    assign bus.irq_ack = ack;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        n = s;
        n.rsp_v = 1'b0;
        n.tk_v = 1'b0;
        if (ack) begin
            n.tk_v = 1'b1;
            n.tk_vec = bus.irq_vec;
            n.tk_lvl = bus.irq_level;
        end
        case (s.st)
            C_IDLE: begin
                if (done_valid_i) begin
                    n.dvec = done_vec_i;
                    n.st = C_CLR;
                end else if (init_valid_i) begin
                    n.addr = init_prio_addr_i;
                    n.data = init_prio_word_i;
                    n.src = init_src_i;
                    n.st = C_PRIO;
                end else if (cmd_valid_i) begin
                    n.write = cmd_write_i;
                    n.addr = cmd_addr_i;
                    n.data = cmd_wdata_i;
                    n.st = C_CMD;
                    if (cmd_write_i && cmd_addr_i == OFF_ENABLE) begin
                        n.en_sh = cmd_wdata_i[NUM_SRC-1:0];
                    end
                    if (cmd_write_i && cmd_addr_i == OFF_CTRL1) begin
                        n.nst_sh = cmd_wdata_i[NEST_OFF_BIT];
                    end
                end
            end
            C_CMD: n.st = s.write ? C_IDLE : C_RD;
            C_RD: begin
                if (bus.rvalid) begin
                    n.rsp_v = 1'b1;
                    n.rsp_d = bus.rdata;
                    n.st = C_IDLE;
                end
            end
            C_PRIO: n.st = C_FLAG;
            C_FLAG: begin
                n.en_sh[s.src] = 1'b1;
                n.st = C_EN;
            end
            C_EN: n.st = C_IDLE;
            C_CLR: n.st = C_RET;
            C_RET: n.st = C_IDLE;
            default: n.st = C_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s <= '0;
            s.st <= C_IDLE;
        end else if (ce_i) begin
            s <= n;
        end
    end

    assign cmd_ready_o = (s.st == C_IDLE) && !done_valid_i && !init_valid_i;
    assign rsp_valid_o = s.rsp_v;
    assign rsp_data_o = s.rsp_d;
    assign taken_valid_o = s.tk_v;
    assign taken_vec_o = s.tk_vec;
    assign taken_level_o = s.tk_lvl;
endmodule // ips_core
`default_nettype wire

// >>> verif/ips_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module ips_asserts
    import ips_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic wr,
    input wire logic rd,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic rvalid,
    input wire logic irq_req,
    input wire logic [LVL_W-1:0] irq_level,
    input wire logic [VEC_W-1:0] irq_vec,
    input wire logic irq_ack,
    input wire logic irq_ret
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ----------------------------------------
    // Register reads
    // ----------------------------------------
    sequence read_s;
        rd && !wr;
    endsequence
    read_answer_a: assert property (read_s |=> rvalid)
        else $error("read not answered");
    rvalid_cause_a: assert property (rvalid |-> $past(rd))
        else $error("read answer without request");
    status_zero_a: assert property (read_s ##0 addr == OFF_STATUS |=>
        rdata[15:12] == 4'h0 && !rdata[7]) else $error("status spare bits set");
    prio_bits_a: assert property (read_s ##0 addr < OFF_STATUS |=>
        (rdata & ~PRIO_MASK[$past(addr[1:0])]) == 16'h0000) else $error("spare bit set");
    // ----------------------------------------
    // Interrupt requests
    // ----------------------------------------
    sequence take_s;
        irq_ack && irq_req && !irq_ret;
    endsequence
    user_level_a: assert property (irq_req && irq_vec >= VEC_USER_BASE |->
        irq_level inside {[4'h1:LVL_USER_MAX]}) else $error("user level out of range");
    trap_level_a: assert property (irq_req && irq_vec < 7'h04 |->
        irq_level == LVL_TRAP_BASE + irq_vec[3:0]) else $error("trap level wrong");
    vec_range_a: assert property (irq_req |-> irq_vec < 7'h04 ||
        (irq_vec >= VEC_USER_BASE && irq_vec < VEC_USER_BASE + 7'h08))
        else $error("vector out of range");
    take_raise_a: assert property (take_s |=> !irq_req ||
        irq_level > $past(irq_level)) else $error("request not above new level");
endmodule // ips_asserts
`default_nettype wire

// >>> verif/ips_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ips_tb;
    import ips_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] src_ev = 8'h00;
    logic [3:0] trap_ev = 4'h0;
    logic [3:0] cur_lvl;
    logic cmd_v = 1'b0;
    logic cmd_w = 1'b0;
    logic [3:0] cmd_a = 4'h0;
    logic [15:0] cmd_d = 16'h0000;
    logic cmd_rdy;
    logic rsp_v;
    logic [15:0] rsp_d;
    logic ini_v = 1'b0;
    logic [2:0] ini_s = 3'h0;
    logic [3:0] ini_a = 4'h0;
    logic [15:0] ini_d = 16'h0000;
    logic done_v = 1'b0;
    logic [6:0] done_n = 7'h00;
    logic take_en = 1'b0;
    logic tk_v;
    logic [6:0] tk_n;
    logic [3:0] tk_l;
    logic [2:0] code;
    logic [15:0] q;
    logic [31:0] seed = 32'hF43E;
    int fail_count = 0;
    int checked = 0;
    int cyc = 0;

    always #20 clk_i = ~clk_i;

    ips_if bus_if();
    ips_ctrl i_ips_ctrl(.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .bus(bus_if),
        .src_event_i(src_ev), .trap_event_i(trap_ev), .cur_level_o(cur_lvl));
    ips_core i_ips_core(.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .bus(bus_if),
        .cmd_valid_i(cmd_v), .cmd_write_i(cmd_w), .cmd_addr_i(cmd_a), .cmd_wdata_i(cmd_d),
        .cmd_ready_o(cmd_rdy), .rsp_valid_o(rsp_v), .rsp_data_o(rsp_d),
        .init_valid_i(ini_v), .init_src_i(ini_s), .init_prio_addr_i(ini_a),
        .init_prio_word_i(ini_d), .done_valid_i(done_v), .done_vec_i(done_n),
        .take_en_i(take_en), .taken_valid_o(tk_v), .taken_vec_o(tk_n), .taken_level_o(tk_l));
    ips_asserts i_ips_asserts(.clk_i(clk_i), .rst_i(rst_i), .addr(bus_if.addr),
        .wr(bus_if.wr), .rd(bus_if.rd), .rdata(bus_if.rdata), .rvalid(bus_if.rvalid),
        .irq_req(bus_if.irq_req), .irq_level(bus_if.irq_level), .irq_vec(bus_if.irq_vec),
        .irq_ack(bus_if.irq_ack), .irq_ret(bus_if.irq_ret));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [6:0] vexp(input int k);
        return (k >= 8) ? VEC_TRAP_BASE + 7'(k - 8) : VEC_USER_BASE + 7'(k);
    endfunction

    function automatic logic [3:0] lexp(input int k, input logic [2:0] c);
        return (k >= 8) ? LVL_TRAP_BASE + 4'(k - 8) : {1'b0, c};
    endfunction

    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        checked++;
        if (got !== exp) begin
            $display("Error %0t: %s got %h expected %h", $time, m, got, exp);
            fail_count++;
        end
    endtask

    task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d);
        int n;
        cmd_w = w;
        cmd_a = a;
        cmd_d = d;
        cmd_v = 1'b1;
        for (n = 0; n < 20 && cmd_rdy !== 1'b1; n++) @(negedge clk_i);
        if (cmd_rdy !== 1'b1) begin
            $display("Error %0t: command not accepted", $time);
            fail_count++;
        end
        @(negedge clk_i);
        cmd_v = 1'b0;
        for (n = 0; n < 8 && !w && rsp_v !== 1'b1; n++) @(negedge clk_i);
        if (w) @(negedge clk_i);
        if (!w && rsp_v !== 1'b1) begin
            $display("Error %0t: read not answered", $time);
            fail_count++;
        end
        q = rsp_d;
    endtask

    task automatic fire(input int k, input logic [2:0] c, input logic exp, input logic [3:0] b);
        int n;
        if (k >= 8)
            trap_ev[k-8] = 1'b1;
        else
            src_ev[k] = 1'b1;
        @(negedge clk_i);
        src_ev = 8'h00;
        trap_ev = 4'h0;
        for (n = 0; n < 16 && tk_v !== 1'b1; n++) @(negedge clk_i);
        chk(16'(tk_v), 16'(exp), "take");
        if (exp) begin
            chk(16'(tk_n), 16'(vexp(k)), "vector");
            chk(16'(tk_l), 16'(lexp(k, c)), "level");
            done_n = vexp(k);
            done_v = 1'b1;
            @(negedge clk_i);
            done_v = 1'b0;
            repeat (10) @(negedge clk_i);
            chk(16'(cur_lvl), 16'(b), "restored level");
        end
    endtask

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        repeat (16) @(posedge clk_i);
        @(negedge clk_i);
        rst_i = 1'b0;
        take_en = 1'b1;
        for (int r = 0; r < 4; r++) begin
            bus(1'b0, 4'(r), 16'h0000);
            chk(q, PRIO_RST[r], "reset value");
        end
        bus(1'b0, OFF_STATUS, 16'h0000);
        chk(q & 16'hFF80, 16'h0000, "status reset");
        $display("test reset done");
        for (int i = 0; i < 16; i++) begin
            seed = lfsr(seed);
            bus(1'b1, 4'(i % 4), seed[15:0]);
            bus(1'b0, 4'(i % 4), 16'h0000);
            chk(q, seed[15:0] & PRIO_MASK[i % 4], "priority rw");
        end
        bus(1'b1, OFF_STATUS, 16'hFFFF);
        bus(1'b0, OFF_STATUS, 16'h0000);
        chk(q & 16'hFF80, 16'h0000, "status read only");
        bus(1'b0, 4'hF, 16'h0000);
        chk(q, 16'h0000, "unmapped");
        $display("test registers done");
        for (int k = 0; k < NUM_SRC; k++) begin
            seed = lfsr(seed);
            code = (k == 0) ? 3'h7 : (k == 1) ? 3'h1 : seed[2:0] | 3'h1;
            ini_s = 3'(k);
            ini_a = 4'(SRC_REG[k]);
            ini_d = 16'(code) << SRC_POS[k];
            ini_v = 1'b1;
            @(negedge clk_i);
            ini_v = 1'b0;
            repeat (8) @(negedge clk_i);
            fire(k, code, 1'b1, 4'h0);
        end
        $display("test sources done");
        bus(1'b1, 4'h0, 16'h0000);
        fire(0, 3'h0, 1'b0, 4'h0);
        bus(1'b1, OFF_FLAGS, 16'h0001);
        bus(1'b1, 4'h0, 16'h7000);
        bus(1'b1, OFF_STAT_LO, 16'(STLO_MASK_ALL));
        fire(0, 3'h7, 1'b0, 4'h0);
        fire(8, 3'h0, 1'b1, 4'h7);
        bus(1'b1, OFF_STAT_LO, 16'h0000);
        fire(0, 3'h7, 1'b1, 4'h0);
        $display("test masking done");
        bus(1'b1, 4'h0, 16'h6070);
        bus(1'b1, OFF_HOLD, 16'h003C);
        fire(1, 3'h7, 1'b1, 4'h0);
        fire(0, 3'h6, 1'b0, 4'h0);
        repeat (30) @(negedge clk_i);
        fire(0, 3'h6, 1'b1, 4'h0);
        $display("test timed disable done");
        bus(1'b1, 4'h0, 16'h2070);
        bus(1'b1, OFF_CTRL1, 16'h8000);
        src_ev = 8'h01;
        @(negedge clk_i);
        src_ev = 8'h02;
        @(negedge clk_i);
        src_ev = 8'h00;
        chk(16'(tk_v), 16'h0001, "nest first take");
        chk(16'(tk_n), 16'(vexp(0)), "nest first vector");
        repeat (8) begin
            @(negedge clk_i);
            chk(16'(tk_v), 16'h0000, "nested take");
        end
        done_n = vexp(0);
        done_v = 1'b1;
        @(negedge clk_i);
        done_v = 1'b0;
        fire(1, 3'h7, 1'b1, 4'h0);
        bus(1'b1, OFF_CTRL1, 16'h0000);
        $display("test nesting done");
        take_en = 1'b0;
        src_ev = 8'h02;
        @(negedge clk_i);
        src_ev = 8'h00;
        bus(1'b0, OFF_STATUS, 16'h0000);
        chk(q, {4'h0, 4'h7, 1'b0, VEC_USER_BASE + 7'h01}, "status pending");
        take_en = 1'b1;
        fire(1, 3'h7, 1'b1, 4'h0);
        $display("test status done");
        conclude();
    end

    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            fail_count++;
            conclude();
        end
    end
endmodule // ips_tb
`default_nettype wire
